// [ipv_assertions.sv]
// Purpose: timing checks on the interrupt priority and vectoring ports
// Assumes: one clock domain, reset active high
// Notes: stacking checks lean on the core holding pc and sp while busy
`timescale 1ns/100ps
module ipv_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic swiExec,
  input wire logic rtiExec,
  input wire logic globalMask,
  input wire logic [15:0] cpuPc,
  input wire logic [15:0] cpuSp,
  input wire logic pinRequestFlag,
  input wire logic pinRequestMask,
  input wire logic busy,
  input wire logic [15:0] busAddr,
  input wire logic [7:0] busWrData,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic setGlobalMask,
  input wire logic pcLoad,
  input wire logic [15:0] pcValue,
  input wire logic spLoad,
  input wire logic [15:0] spValue,
  input wire logic regRestore,
  input wire logic [7:0] pendingStatusRegA
);
  // pin request as the status flag should see it
  wire pinReq = pinRequestFlag & ~pinRequestMask;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_swi_any_mask: assert property (!busy && swiExec |-> ##[1:2] busWrite)
    else $error("software entry did not start");
  a_swi_stacks_pc: assert property (!busy && swiExec |-> ##[1:2]
    (busWrite && busAddr == cpuSp && busWrData == cpuPc[7:0]))
    else $error("software entry stacked wrong pc byte");
  a_mask_blocks_hw: assert property (!busy && globalMask && !swiExec && !rtiExec |=> !busy)
    else $error("masked request started a sequence");
  a_mask_after_stack: assert property (setGlobalMask |-> busRead && $past(busWrite))
    else $error("mask set out of place");
  a_vec_low_next: assert property (setGlobalMask |=> busRead && busAddr == $past(busAddr) + 16'h1)
    else $error("vector low byte not next");
  a_vec_legal: assert property (setGlobalMask |-> busAddr inside {16'hfffc, 16'hfffa,
    16'hfff6, 16'hfff4, 16'hfff2, 16'hffec, 16'hffe0, 16'hffde})
    else $error("unknown vector address");
  a_flags_unused: assert property (pendingStatusRegA[7] == 1'b0 && pendingStatusRegA[3] == 1'b0 &&
    pendingStatusRegA[1:0] == 2'h0)
    else $error("unused status bit set");
  a_flag_pin: assert property (!$past(reset) |-> pendingStatusRegA[2] == $past(pinReq))
    else $error("pin flag does not follow request");
  a_rti_fetch: assert property (regRestore |->
    pcLoad && spLoad && pcValue == $past(busAddr, 2) && $past(busRead, 2) &&
    $past(busAddr) == pcValue + 16'h1)
    else $error("return fetch order wrong");
  a_entry_frame: assert property (pcLoad && spLoad && !regRestore |->
    spValue == $past(busAddr, 3) - 16'h1)
    else $error("entry frame not five bytes");

  // main scenarios reached
  c_swi: cover property (!busy && swiExec && globalMask);
  c_ret: cover property (regRestore);
  c_entry: cover property (pcLoad && spLoad);
  c_chain: cover property (regRestore && busy);
endmodule

bind ipv_interrupt_priority_vectoring ipv_checker i_ipv_checker (.clk, .reset, .swiExec,
  .rtiExec, .globalMask, .cpuPc, .cpuSp, .pinRequestFlag, .pinRequestMask, .busy, .busAddr,
  .busWrData, .busWrite, .busRead, .setGlobalMask, .pcLoad, .pcValue, .spLoad, .spValue,
  .regRestore, .pendingStatusRegA);

// [ipv_cfg.svh]
// Purpose: constants of the interrupt priority and vectoring block
// Assumes: 8-bit data, 16-bit addresses, stack grows downward
// Notes: vectors are the high-byte address; the low byte sits one above
`ifndef IPV_CFG_SVH
`define IPV_CFG_SVH

`define IPV_VEC_RESET 16'hfffe
`define IPV_VEC_SWI 16'hfffc
`define IPV_VEC_PIN 16'hfffa
`define IPV_VEC_CHAN0 16'hfff6
`define IPV_VEC_CHAN1 16'hfff4
`define IPV_VEC_WRAP 16'hfff2
`define IPV_VEC_TEST 16'hffec
`define IPV_VEC_KEYPAD 16'hffe0
`define IPV_VEC_CONV 16'hffde

// factory contents of the test vector pair
`define IPV_TEST_ROM_HI 8'h00
`define IPV_TEST_ROM_LO 8'h83

// flag positions inside the three status bytes
`define IPV_BIT_PIN 2
`define IPV_BIT_CHAN0 4
`define IPV_BIT_CHAN1 5
`define IPV_BIT_WRAP 6
`define IPV_BIT_TEST 1
`define IPV_BIT_KEYPAD 7
`define IPV_BIT_CONV 0

`define IPV_CCR_IBIT 3
`define IPV_FRAME_LEN 16'h0005
`define IPV_LAST_SLOT 3'h4

// capture slots for bytes read back from memory
`define IPV_TAG_CCR 4'h0
`define IPV_TAG_VECH 4'h5
`define IPV_TAG_VECL 4'h6
`define IPV_TAG_OPC 4'h7
`define IPV_TAG_OPR 4'h8
`endif

// [ipv_interrupt_priority_vectoring.sv]
// Purpose: interrupt arbitration, stacking, vector fetch and return sequencing
// Assumes: memory answers a read in the cycle its registered address is shown
// Notes: the core stalls while busy is high and takes pc/sp/registers on the pulses
// Summary of operation
// RULE1 - software interrupt taken regardless of global mask
// RULE2 - software stacks pc, hardware stacks pc minus one
// RULE3 - global mask and local enable gate maskable sources
// RULE4 - only maskable sources own status flags
// RULE5 - sources mirror into fixed status flag positions
// RULE6 - fixed priority from reset down to converter
// RULE7 - reset, software, pin, channel0 vector addresses
// RULE8 - channel1, wrap, keypad, converter vector addresses
// RULE9 - test vector reserved, contents 00 and 83
// RULE10 - return pulls upward, then fetches opcode, operand
// RULE11 - mask set after stacking, before vector fetch; setGlobalMask rises with the vector high read instead
// RULE12 - hardware interrupt waits for instruction end
// RULE13 - highest pending first, rechecked at return
// RULE14 - high index byte never stacked
// RULE15 - flags follow requests, read-only, reset zero
`timescale 1ns/100ps
`include "ipv_cfg.svh"

module ipv_interrupt_priority_vectoring
  import ipv_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic instrDone,
  input wire logic swiExec,
  input wire logic rtiExec,
  input wire logic globalMask,
  input wire logic [15:0] cpuPc,
  input wire logic [15:0] cpuSp,
  input wire logic [7:0] cpuA,
  input wire logic [7:0] cpuX,
  input wire logic [7:0] cpuCcr,
  input wire logic [7:0] busRdData,
  input wire logic pinRequestFlag,
  input wire logic pinRequestMask,
  input wire logic timerChan0Flag,
  input wire logic timerChan0Enable,
  input wire logic timerChan1Flag,
  input wire logic timerChan1Enable,
  input wire logic timerWrapFlag,
  input wire logic timerWrapEnable,
  input wire logic testRequest,
  input wire logic keypadFlag,
  input wire logic keypadMask,
  input wire logic conversionDoneFlag,
  input wire logic conversionIrqEnable,
  output logic busy,
  output logic [15:0] busAddr,
  output logic [7:0] busWrData,
  output logic busWrite,
  output logic busRead,
  output logic setGlobalMask,
  output logic pcLoad,
  output logic [15:0] pcValue,
  output logic spLoad,
  output logic [15:0] spValue,
  output logic regRestore,
  output logic [7:0] restA,
  output logic [7:0] restX,
  output logic [7:0] restCcr,
  output logic [7:0] fetchOpcode,
  output logic [7:0] fetchOperand,
  output logic [2:0] activeSource,
  output logic [7:0] pendingStatusRegA,
  output logic [7:0] pendingStatusRegB,
  output logic [7:0] pendingStatusRegC
);

  ipv_state_t state_r, stateNxt;
  logic [2:0] cnt_r, cntNxt;
  logic [15:0] sp_r, pcSave_r, vec_r;
  logic [7:0] a_r, x_r, ccr_r;
  logic fromReset_r, isTest_r;
  logic [3:0] readTag_r;
  logic [7:0] pull_r [0:8];
  logic [15:0] busAddr_r;
  logic [7:0] busWrData_r, opr_r, statA_r, statB_r, statC_r;
  logic busWrite_r, busRead_r, setMask_r, pcLoad_r, spLoad_r, restore_r;
  logic [15:0] pcValue_r, spValue_r;
  logic [2:0] src_r;

  // per-source request after its local enable; pin and keypad use active-high masks
  wire logic [6:0] localReq = {conversionDoneFlag & conversionIrqEnable,
                               keypadFlag & ~keypadMask,
                               testRequest,
                               timerWrapFlag & timerWrapEnable,
                               timerChan1Flag & timerChan1Enable,
                               timerChan0Flag & timerChan0Enable,
                               pinRequestFlag & ~pinRequestMask}; // RULE3
  wire logic anyReq = |localReq;

  // fixed priority pick, lowest index wins
  logic [2:0] winner;
  always_comb begin
    winner = IPV_SRC_NONE;
    for (int i = 6; i >= 0; i--) begin
      if (localReq[i]) winner = 3'(i); // RULE6 RULE13
    end
  end

  // vector of the winning source; the test pair is never fetched from memory
  logic [15:0] winVec;
  always_comb begin
    case (winner)
      IPV_SRC_PIN: winVec = `IPV_VEC_PIN; // RULE7
      IPV_SRC_CHAN0: winVec = `IPV_VEC_CHAN0; // RULE7
      IPV_SRC_CHAN1: winVec = `IPV_VEC_CHAN1; // RULE8
      IPV_SRC_WRAP: winVec = `IPV_VEC_WRAP; // RULE8
      IPV_SRC_TEST: winVec = `IPV_VEC_TEST; // RULE9
      IPV_SRC_KEYPAD: winVec = `IPV_VEC_KEYPAD; // RULE8
      IPV_SRC_CONV: winVec = `IPV_VEC_CONV; // RULE8
      default: winVec = `IPV_VEC_RESET;
    endcase
  end

  // hardware entry: only at an instruction boundary and only with the mask clear
  wire logic hwTakeIdle = instrDone & ~globalMask & anyReq; // RULE12 RULE3
  wire logic hwTakeRet = ~pull_r[0][`IPV_CCR_IBIT] & anyReq; // RULE13
  wire logic [15:0] restPc = {pull_r[3], pull_r[4]};
  wire logic chainIn = (state_r == IPV_FETCH);

  // test vector bytes come from the fixed contents instead of the bus
  wire logic [7:0] rdByte = (isTest_r && readTag_r == `IPV_TAG_VECH) ? `IPV_TEST_ROM_HI :
                            (isTest_r && readTag_r == `IPV_TAG_VECL) ? `IPV_TEST_ROM_LO :
                            busRdData; // RULE9

  // stacked bytes in push order: pcl, pch, x, a, ccr; no high index byte
  logic [7:0] pushByte;
  always_comb begin
    case (cnt_r)
      3'h0: pushByte = pcSave_r[7:0];
      3'h1: pushByte = pcSave_r[15:8];
      3'h2: pushByte = x_r;
      3'h3: pushByte = a_r;
      default: pushByte = ccr_r;
    endcase
  end // RULE14

  logic startEntry, takeSwi, issueRd, issueWr, markI, loadVec, endFetch;
  logic [15:0] issueAddr;
  logic [3:0] issueTag;
  always_comb begin
    stateNxt = state_r;
    cntNxt = cnt_r + 3'h1;
    startEntry = 1'b0;
    takeSwi = 1'b0;
    issueRd = 1'b0;
    issueWr = 1'b0;
    issueAddr = 16'h0000;
    issueTag = 4'h0;
    markI = 1'b0;
    loadVec = 1'b0;
    endFetch = 1'b0;
    case (state_r)
      IPV_IDLE: begin
        cntNxt = 3'h0;
        if (swiExec) begin
          startEntry = 1'b1; // RULE1
          takeSwi = 1'b1;
        end else if (hwTakeIdle) begin
          startEntry = 1'b1;
        end else if (rtiExec) begin
          stateNxt = IPV_PULL;
        end
        if (startEntry) stateNxt = IPV_PUSH;
      end
      IPV_PUSH: begin
        issueWr = 1'b1;
        issueAddr = sp_r - 16'(cnt_r);
        if (cnt_r == `IPV_LAST_SLOT) begin
          stateNxt = IPV_VECT;
          cntNxt = 3'h0;
        end
      end
      IPV_VECT: begin
        issueRd = (cnt_r != 3'h2);
        // mask rises with the vector high read, once the last byte is stacked; not after reset
        markI = (cnt_r == 3'h0) && !fromReset_r; // RULE11
        issueAddr = vec_r + 16'(cnt_r[0]); // high byte first
        issueTag = (cnt_r == 3'h0) ? `IPV_TAG_VECH : `IPV_TAG_VECL;
        if (cnt_r == 3'h2) begin
          loadVec = 1'b1;
          stateNxt = IPV_IDLE;
          cntNxt = 3'h0;
        end
      end
      IPV_PULL: begin
        issueRd = 1'b1;
        issueAddr = sp_r + 16'h0001 + 16'(cnt_r); // RULE10
        issueTag = {1'b0, cnt_r};
        if (cnt_r == `IPV_LAST_SLOT) begin
          stateNxt = IPV_FETCH;
          cntNxt = 3'h0;
        end
      end
      IPV_FETCH: begin
        // slot 0 waits for the last pulled byte to land
        issueRd = (cnt_r == 3'h1) || (cnt_r == 3'h2);
        issueAddr = restPc + 16'(cnt_r == 3'h2); // RULE10
        issueTag = (cnt_r == 3'h1) ? `IPV_TAG_OPC : `IPV_TAG_OPR;
        if (cnt_r == 3'h3) begin
          endFetch = 1'b1;
          cntNxt = 3'h0;
          startEntry = hwTakeRet; // RULE13
          stateNxt = hwTakeRet ? IPV_PUSH : IPV_IDLE;
        end
      end
      default: begin
        stateNxt = IPV_IDLE;
        cntNxt = 3'h0;
      end
    endcase
  end

  // sequencer and frame capture; reset starts with the reset vector fetch
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= IPV_VECT;
      cnt_r <= 3'h0;
      vec_r <= `IPV_VEC_RESET; // RULE6 RULE7
      fromReset_r <= 1'b1;
      isTest_r <= 1'b0;
      sp_r <= 16'h0000;
      pcSave_r <= 16'h0000;
      a_r <= 8'h00;
      x_r <= 8'h00;
      ccr_r <= 8'h00;
      src_r <= IPV_SRC_NONE;
    end else begin
      state_r <= stateNxt;
      cnt_r <= cntNxt;
      if (startEntry) begin
        fromReset_r <= 1'b0;
        vec_r <= takeSwi ? `IPV_VEC_SWI : winVec;
        isTest_r <= ~takeSwi && (winner == IPV_SRC_TEST);
        src_r <= takeSwi ? IPV_SRC_NONE : winner;
        sp_r <= chainIn ? sp_r + `IPV_FRAME_LEN : cpuSp;
        // after a return the opcode is only prefetched, so the restored pc is resumed
        pcSave_r <= takeSwi ? cpuPc : (chainIn ? restPc : cpuPc - 16'h0001); // RULE2
        a_r <= chainIn ? pull_r[1] : cpuA;
        x_r <= chainIn ? pull_r[2] : cpuX;
        ccr_r <= chainIn ? pull_r[0] : cpuCcr;
      end else if (state_r == IPV_IDLE && rtiExec) begin
        sp_r <= cpuSp;
      end
    end
  end

  // bytes read back land one cycle after their address is shown
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 9; i++) pull_r[i] <= 8'h00;
    end else if (busRead_r) begin
      pull_r[readTag_r] <= rdByte;
    end
  end

  // registered bus and core pulses
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busAddr_r <= 16'h0000;
      busWrData_r <= 8'h00;
      busWrite_r <= 1'b0;
      busRead_r <= 1'b0;
      readTag_r <= 4'h0;
      setMask_r <= 1'b0;
      pcLoad_r <= 1'b0;
      spLoad_r <= 1'b0;
      restore_r <= 1'b0;
      pcValue_r <= 16'h0000;
      spValue_r <= 16'h0000;
      opr_r <= 8'h00;
    end else begin
      busAddr_r <= issueAddr;
      busWrData_r <= issueWr ? pushByte : 8'h00;
      busWrite_r <= issueWr;
      busRead_r <= issueRd;
      readTag_r <= issueTag;
      setMask_r <= markI; // RULE11
      pcLoad_r <= loadVec | endFetch;
      spLoad_r <= (loadVec & ~fromReset_r) | endFetch;
      restore_r <= endFetch;
      if (loadVec) begin
        pcValue_r <= {pull_r[5], rdByte};
        spValue_r <= sp_r - `IPV_FRAME_LEN;
      end else if (endFetch) begin
        pcValue_r <= restPc;
        spValue_r <= sp_r + `IPV_FRAME_LEN;
        opr_r <= rdByte;
      end
    end
  end

  // status flags follow requests; reset and software entry own no bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      statA_r <= 8'h00;
      statB_r <= 8'h00;
      statC_r <= 8'h00;
    end else begin
      statA_r <= 8'h00; // RULE15
      statA_r[`IPV_BIT_PIN] <= localReq[IPV_SRC_PIN]; // RULE5 RULE4
      statA_r[`IPV_BIT_CHAN0] <= localReq[IPV_SRC_CHAN0]; // RULE5
      statA_r[`IPV_BIT_CHAN1] <= localReq[IPV_SRC_CHAN1]; // RULE5
      statA_r[`IPV_BIT_WRAP] <= localReq[IPV_SRC_WRAP]; // RULE5
      statB_r <= 8'h00;
      statB_r[`IPV_BIT_TEST] <= localReq[IPV_SRC_TEST]; // RULE5
      statB_r[`IPV_BIT_KEYPAD] <= localReq[IPV_SRC_KEYPAD]; // RULE5
      statC_r <= 8'h00;
      statC_r[`IPV_BIT_CONV] <= localReq[IPV_SRC_CONV]; // RULE5
    end
  end

  assign busy = (state_r != IPV_IDLE) | busRead_r;
  assign busAddr = busAddr_r;
  assign busWrData = busWrData_r;
  assign busWrite = busWrite_r;
  assign busRead = busRead_r;
  assign setGlobalMask = setMask_r;
  assign pcLoad = pcLoad_r;
  assign pcValue = pcValue_r;
  assign spLoad = spLoad_r;
  assign spValue = spValue_r;
  assign regRestore = restore_r;
  assign restA = pull_r[1];
  assign restX = pull_r[2];
  assign restCcr = pull_r[0];
  assign fetchOpcode = pull_r[7];
  assign fetchOperand = opr_r;
  assign activeSource = src_r;
  assign pendingStatusRegA = statA_r;
  assign pendingStatusRegB = statB_r;
  assign pendingStatusRegC = statC_r;

endmodule

// [ipv_mem_model.sv]
// Purpose: memory seen by the vectoring block
// Assumes: combinational read in the cycle busRead is high
// Notes: contents are a fold of the address so expectations need no table
`timescale 1ns/100ps
module ipv_mem_model (
  input wire logic [15:0] busAddr,
  input wire logic busRead,
  output logic [7:0] busRdData
);
  // outside reads the data lines show the inverse, so stale data is never mistaken
  assign busRdData = busRead ? busAddr[7:0] ^ busAddr[15:8] : ~(busAddr[7:0] ^ busAddr[15:8]);
endmodule

// [ipv_pkg.sv]
// Purpose: types of the interrupt priority and vectoring block
// Assumes: nothing beyond the constants header
// Notes: states are one-hot
package ipv_pkg;
  typedef enum logic [4:0] {
    IPV_IDLE = 5'h01,
    IPV_PUSH = 5'h02,
    IPV_VECT = 5'h04,
    IPV_PULL = 5'h08,
    IPV_FETCH = 5'h10
  } ipv_state_t;

  // maskable sources, index 0 is the highest priority
  typedef enum logic [2:0] {
    IPV_SRC_PIN = 3'h0,
    IPV_SRC_CHAN0 = 3'h1,
    IPV_SRC_CHAN1 = 3'h2,
    IPV_SRC_WRAP = 3'h3,
    IPV_SRC_TEST = 3'h4,
    IPV_SRC_KEYPAD = 3'h5,
    IPV_SRC_CONV = 3'h6,
    IPV_SRC_NONE = 3'h7
  } ipv_src_t;
endpackage

// [test_interrupt_priority_vectoring.sv]
// Purpose: self-checking bench for interrupt priority and vectoring
// Assumes: memory model folds address bytes into data
// Notes: the monitor matches each bus write and load pulse to the oldest note
`timescale 1ns/100ps
module test_interrupt_priority_vectoring;
  logic clk, reset, instrDone, swiExec, rtiExec, globalMask, busy, busWrite, busRead;
  logic pcLoad, spLoad, regRestore;
  logic [15:0] cpuPc, cpuSp, busAddr, pcValue, spValue;
  logic setGlobalMask;
  logic [2:0] activeSource;
  logic [7:0] cpuA, cpuX, cpuCcr, busRdData, busWrData, restA, restX, restCcr;
  logic [7:0] fetchOpcode, fetchOperand, pendingStatusRegA, pendingStatusRegB, pendingStatusRegC;
  logic [6:0] req, en;
  logic [39:0] wq[$], lq[$], rq[$];
  logic [15:0] vt [7] = '{16'hfffa, 16'hfff6, 16'hfff4, 16'hfff2, 16'hffec, 16'hffe0, 16'hffde};
  integer fails = 0, compares = 0, seed = 32'h16fa, i;

  ipv_interrupt_priority_vectoring i_ipv_interrupt_priority_vectoring (.clk, .reset, .instrDone,
    .swiExec, .rtiExec, .globalMask, .cpuPc, .cpuSp, .cpuA, .cpuX, .cpuCcr, .busRdData,
    .pinRequestFlag(req[0]), .pinRequestMask(!en[0]), .timerChan0Flag(req[1]),
    .timerChan0Enable(en[1]), .timerChan1Flag(req[2]), .timerChan1Enable(en[2]),
    .timerWrapFlag(req[3]), .timerWrapEnable(en[3]), .testRequest(req[4]), .keypadFlag(req[5]),
    .keypadMask(!en[5]), .conversionDoneFlag(req[6]), .conversionIrqEnable(en[6]), .busy,
    .busAddr, .busWrData, .busWrite, .busRead, .setGlobalMask, .pcLoad, .pcValue, .spLoad,
    .spValue, .regRestore, .restA, .restX, .restCcr, .fetchOpcode, .fetchOperand,
    .activeSource, .pendingStatusRegA, .pendingStatusRegB, .pendingStatusRegC);
  ipv_mem_model i_ipv_mem_model (.busAddr, .busRead, .busRdData);

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  function automatic logic [7:0] mf(input logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction

  // test source has no local enable, so it is forced into the gate
  function automatic logic [23:0] fx(input logic [6:0] r, e);
    logic [6:0] p;
    p = r & (e | 7'h10);
    return {1'b0, p[3:1], 1'b0, p[0], 2'h0, p[5], 5'h0, p[4], 1'b0, 7'h0, p[6]};
  endfunction

  task automatic cmp(input logic [39:0] g, e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
    end
  endtask

  // one compare task per kind of result, all counted by cmp
  task automatic checkWrite(input logic [39:0] g, e);
    cmp(g, e);
  endtask

  task automatic checkLoad(input logic [39:0] g, e);
    cmp(g, e);
  endtask

  task automatic checkRestore(input logic [39:0] g, e);
    cmp(g, e);
  endtask

  task automatic checkFlags(input logic [39:0] g, e);
    cmp(g, e);
  endtask

  task automatic checkMask(input logic [39:0] g, e);
    cmp(g, e);
  endtask

  task summarize;
    fails = fails + wq.size() + lq.size() + rq.size();
    if (fails == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // one entry: notes the five stacked bytes and the load, then raises the request
  task automatic entry(input logic sw, input logic [6:0] r);
    logic [15:0] pc, sp, v, ps;
    logic [7:0] a, x, c;
    int k;
    pc = 16'($random(seed));
    sp = 16'($random(seed));
    a = 8'($random(seed));
    x = 8'($random(seed));
    c = 8'($random(seed));
    k = 0;
    while (!sw && !r[k]) k++;
    v = sw ? 16'hfffc : vt[k];
    ps = sw ? pc : pc - 16'h1;
    wq.push_back({sp, ps[7:0]});
    wq.push_back({sp - 16'h1, ps[15:8]});
    wq.push_back({sp - 16'h2, x});
    wq.push_back({sp - 16'h3, a});
    wq.push_back({sp - 16'h4, c});
    lq.push_back({sw ? 3'h7 : 3'(k), v == 16'hffec ? 16'h0083 : {mf(v), mf(v + 16'h1)},
      sp - 16'h5});
    @(posedge clk);
    cpuPc <= pc;
    cpuSp <= sp;
    cpuA <= a;
    cpuX <= x;
    cpuCcr <= c;
    req <= r;
    swiExec <= sw;
    instrDone <= !sw;
    globalMask <= sw;
    @(posedge clk);
    swiExec <= 0;
    instrDone <= 0;
    req <= 0;
    repeat (12) @(posedge clk);
  endtask

  // one return: notes the pulled frame and load; a pending request chains a new entry
  task automatic ret(input logic [15:0] s, input logic [2:0] src, input logic [6:0] r);
    logic [15:0] p;
    p = {mf(s + 16'h4), mf(s + 16'h5)};
    lq.push_back({src, p, s + 16'h5});
    rq.push_back({mf(s + 16'h1), mf(s + 16'h2), mf(s + 16'h3), mf(p), mf(p + 16'h1)});
    if (r != 7'h00) begin
      // chained frame goes back where it was pulled from, with the restored pc
      wq.push_back({s + 16'h5, p[7:0]});
      wq.push_back({s + 16'h4, p[15:8]});
      wq.push_back({s + 16'h3, mf(s + 16'h3)});
      wq.push_back({s + 16'h2, mf(s + 16'h2)});
      wq.push_back({s + 16'h1, mf(s + 16'h1)});
      lq.push_back({src, mf(vt[src]), mf(vt[src] + 16'h1), s});
    end
    @(posedge clk);
    cpuSp <= s;
    req <= r;
    rtiExec <= 1'b1;
    @(posedge clk);
    rtiExec <= 1'b0;
    repeat (12) @(posedge clk);
    req <= 7'h00;
    repeat (12) @(posedge clk);
  endtask

  // results are matched in arrival order; a result with no note fails on x
  always @(posedge clk) begin
    if (!reset && busWrite) checkWrite({busAddr, busWrData},
      wq.size() ? wq.pop_front() : 'x);
    if (!reset && pcLoad) checkLoad({activeSource, pcValue, spLoad ? spValue : 16'h0},
      lq.size() ? lq.pop_front() : 'x);
    if (!reset && regRestore) checkRestore({restCcr, restA, restX, fetchOpcode, fetchOperand},
      rq.size() ? rq.pop_front() : 'x);
    if (!reset && setGlobalMask) checkMask({busRead, busWrite}, 2'b10);
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    summarize;
  end

  initial begin
    reset = 1;
    {instrDone, swiExec, rtiExec, globalMask, cpuPc, cpuSp, cpuA, cpuX, cpuCcr, req, en} = '0;
    lq.push_back({3'h7, mf(16'hfffe), mf(16'hffff), 16'h0});
    repeat (10) @(posedge clk);
    reset <= 0;
    repeat (8) @(posedge clk);
    en <= 7'h7f;
    entry(1'b1, 7'h01);
    for (i = 0; i < 7; i++) entry(1'b0, 7'h7f << i);
    // restored mask set at 2007: no chain; clear at 2010 with keypad pending: chain
    ret(16'h2007, 3'h6, 7'h00);
    ret(16'h2010, 3'h5, 7'h20);
    // masked requests only show in the flags
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      req <= 7'($random(seed));
      en <= 7'($random(seed));
      globalMask <= 1;
      instrDone <= 1;
      @(posedge clk);
      instrDone <= 0;
      @(posedge clk);
      #1;
      checkFlags({pendingStatusRegA, pendingStatusRegB, pendingStatusRegC}, fx(req, en));
    end
    // mask clear but every gated source disabled: no entry may start
    @(posedge clk);
    req <= 7'h6f;
    en <= 7'h00;
    globalMask <= 0;
    instrDone <= 1;
    @(posedge clk);
    instrDone <= 0;
    req <= 0;
    repeat (12) @(posedge clk);
    summarize;
  end
endmodule
